// *** rtl/pcr_defs.vh ***
// Purpose: offsets, field positions, reset values for partner caps / remap regs
// Assumes: included by its bare name
// Notes:   byte addresses are four times the register index
`ifndef PCR_DEFS_VH
`define PCR_DEFS_VH
`define PCR_IDX_RSVD_A      8'h34
`define PCR_IDX_CAPS        8'h35
`define PCR_IDX_RSVD_B      8'h36
`define PCR_IDX_DES_ADDR    8'h37
`define PCR_IDX_RSVD_C      8'h38
`define PCR_IDX_TGT0        8'h39
`define PCR_IDX_TGT1        8'h3a
`define PCR_IDX_CTRL        8'h40
`define PCR_IDX_ALIAS0      8'h41
`define PCR_IDX_ALIAS1      8'h42
`define PCR_IDX_STATUS      8'h43
`define PCR_CAP_FREEZE      7
`define PCR_CAP_SELFTEST    5
`define PCR_CAP_PARTNER_MULTIPORT       4
`define PCR_CTRL_PASS       0
`define PCR_CAPS_RESET      8'h00
`define PCR_DES_RESET       7'h3d
`define PCR_TGT_RESET       7'h00
`define PCR_ALIAS_RESET     7'h00
`define PCR_RSVD_RESET      8'h00
`endif

// *** rtl/pcr_slot_match.v ***
// Purpose: one alias slot compare with its physical target address
// Assumes: no clock, pure combinational compare used by the register bank
// Notes:   a slot with alias zero never matches
`timescale 1ns/1ps
module pcr_slot_match #(
  parameter AW = 7
) (
  input  wire [AW-1:0] alias_in,
  input  wire [AW-1:0] target_in,
  input  wire [AW-1:0] addr_in,
  output wire          hit_out,
  output wire [AW-1:0] target_out
);
  assign hit_out    = (alias_in != {AW{1'b0}}) && (alias_in == addr_in);
  assign target_out = hit_out ? target_in : {AW{1'b0}};
endmodule

// *** rtl/pcr_regs.v ***
// Purpose: partner capability, partner address and target remap registers
// Assumes: classic wishbone slave, 32-bit data, 8-bit registers in low byte
// Notes:   one ack or err per request, one cycle after strobe; ack drops next cycle
//          unmapped or misaligned access answers with err and writes nothing
//          back channel loads win over a bus write in the same cycle
//          alias value zero never matches; remap output is zero on a miss
`timescale 1ns/1ps
`include "pcr_defs.vh"
module pcr_regs #(
  parameter NSLOT = 2
) (
  input  wire        mclk_in,
  input  wire        reset_in,
  input  wire        wb_cyc_in,
  input  wire        wb_stb_in,
  input  wire        wb_we_in,
  input  wire [31:0] wb_adr_in,
  input  wire [31:0] wb_dat_in,
  input  wire [3:0]  wb_sel_in,
  output reg  [31:0] wb_dat_out,
  output reg         wb_ack_out,
  output reg         wb_err_out,
  input  wire        bc_link_detect_in,
  input  wire        bc_selftest_in,
  input  wire        bc_multiport_in,
  input  wire [3:0]  bc_port_num_in,
  input  wire        bc_addr_valid_in,
  input  wire [6:0]  bc_des_addr_in,
  input  wire        i2c_req_in,
  input  wire [6:0]  i2c_addr_in,
  output reg         fwd_valid_out,
  output reg  [6:0]  fwd_addr_out,
  output reg         fwd_hit_out
);
  // ***************************************
  // storage
  // ***************************************
  reg  [7:0] caps;
  reg  [7:0] rsvd_a;
  reg  [7:0] rsvd_b;
  reg  [7:0] rsvd_c;
  reg  [6:0] des_addr;
  reg        freeze_partner_address;
  reg  [6:0] tgt  [0:NSLOT-1];
  reg  [6:0] alias_addr [0:NSLOT-1];
  reg        pass_enable;
  reg        link_q;
  reg        caps_loaded;
  wire       freeze_partner_caps;
  wire       link_rise;
  wire       req;
  wire       wr;
  wire [7:0] idx;
  reg  [7:0] rd_byte;
  reg        mapped;
  wire [NSLOT-1:0] hits;
  wire [6:0] tsel [0:NSLOT-1];
  reg  [6:0] next_target;
  integer    i;
  integer    k;

  assign freeze_partner_caps = caps[`PCR_CAP_FREEZE];
  assign req       = wb_cyc_in && wb_stb_in && !wb_ack_out && !wb_err_out;
  assign wr        = req && wb_we_in && wb_sel_in[0] && mapped;
  assign idx       = wb_adr_in[9:2];
  assign link_rise = bc_link_detect_in && !link_q;

  // ***************************************
  // per register write strobes
  // ***************************************
  wire       wr_caps;
  wire       wr_des_addr;
  wire       wr_rsvd_a;
  wire       wr_rsvd_b;
  wire       wr_rsvd_c;
  wire       wr_ctrl;
  wire       wr_tgt0;
  wire       wr_tgt1;
  wire       wr_alias0;
  wire       wr_alias1;

  assign wr_caps     = wr && (idx == `PCR_IDX_CAPS);
  assign wr_des_addr = wr && (idx == `PCR_IDX_DES_ADDR);
  assign wr_rsvd_a   = wr && (idx == `PCR_IDX_RSVD_A);
  assign wr_rsvd_b   = wr && (idx == `PCR_IDX_RSVD_B);
  assign wr_rsvd_c   = wr && (idx == `PCR_IDX_RSVD_C);
  assign wr_ctrl     = wr && (idx == `PCR_IDX_CTRL);
  assign wr_tgt0     = wr && (idx == `PCR_IDX_TGT0);
  assign wr_tgt1     = wr && (idx == `PCR_IDX_TGT1);
  assign wr_alias0   = wr && (idx == `PCR_IDX_ALIAS0);
  assign wr_alias1   = wr && (idx == `PCR_IDX_ALIAS1);

  // ***************************************
  // address decode and read mux
  // ***************************************
  always @* begin
    mapped  = 1'b1;
    rd_byte = 8'h00;
    case (idx)
      `PCR_IDX_RSVD_A:   rd_byte = rsvd_a;
      `PCR_IDX_CAPS:     rd_byte = caps;
      `PCR_IDX_RSVD_B:   rd_byte = rsvd_b;
      `PCR_IDX_DES_ADDR: rd_byte = {des_addr, freeze_partner_address};
      `PCR_IDX_RSVD_C:   rd_byte = rsvd_c;
      `PCR_IDX_TGT0:     rd_byte = {tgt[0], 1'b0};
      `PCR_IDX_TGT1:     rd_byte = {tgt[1], 1'b0};
      `PCR_IDX_CTRL:     rd_byte = {7'h00, pass_enable};
      `PCR_IDX_ALIAS0:   rd_byte = {alias_addr[0], 1'b0};
      `PCR_IDX_ALIAS1:   rd_byte = {alias_addr[1], 1'b0};
      `PCR_IDX_STATUS:   rd_byte = {6'h00, caps_loaded, bc_link_detect_in};
      default:           mapped  = 1'b0;
    endcase
    if (wb_adr_in[31:10] != 22'h000000 || wb_adr_in[1:0] != 2'b00) begin
      mapped = 1'b0;
    end
  end

  // ***************************************
  // bus answer
  // ***************************************
  always @(posedge mclk_in) begin
    if (reset_in) begin
      wb_ack_out <= 1'b0;
      wb_err_out <= 1'b0;
      wb_dat_out <= 32'h00000000;
    end else begin
      wb_ack_out <= req && mapped;
      wb_err_out <= req && !mapped;
      if (req && mapped && !wb_we_in) begin
        wb_dat_out <= {24'h000000, rd_byte};
      end
    end
  end

  // ***************************************
  // capability register
  // ***************************************
  always @(posedge mclk_in) begin
    if (reset_in) begin
      link_q      <= 1'b0;
      caps        <= `PCR_CAPS_RESET;
    end else begin
      link_q <= bc_link_detect_in;
      if (wr_caps) begin
        caps <= wb_dat_in[7:0];
      end
      if (link_rise && !freeze_partner_caps) begin
        caps[`PCR_CAP_SELFTEST] <= bc_selftest_in;
        caps[`PCR_CAP_PARTNER_MULTIPORT]    <= bc_multiport_in;
        caps[3:0]               <= bc_port_num_in;
      end
    end
  end

  // ***************************************
  // capability load status
  // ***************************************
  always @(posedge mclk_in) begin
    if (reset_in) begin
      caps_loaded <= 1'b0;
    end else begin
      if (!bc_link_detect_in) begin
        caps_loaded <= 1'b0;
      end
      if (link_rise && !freeze_partner_caps) begin
        caps_loaded <= 1'b1;
      end
    end
  end

  // ***************************************
  // partner address
  // ***************************************
  always @(posedge mclk_in) begin
    if (reset_in) begin
      des_addr               <= `PCR_DES_RESET;
      freeze_partner_address <= 1'b0;
    end else begin
      if (wr_des_addr) begin
        des_addr               <= wb_dat_in[7:1];
        freeze_partner_address <= wb_dat_in[0];
      end
      if (bc_addr_valid_in && !freeze_partner_address) begin
        des_addr <= bc_des_addr_in;
      end
    end
  end

  // ***************************************
  // reserved bytes and pass-through control
  // ***************************************
  always @(posedge mclk_in) begin
    if (reset_in) begin
      rsvd_a      <= `PCR_RSVD_RESET;
      rsvd_b      <= `PCR_RSVD_RESET;
      rsvd_c      <= `PCR_RSVD_RESET;
      pass_enable <= 1'b0;
    end else begin
      if (wr_rsvd_a) begin
        rsvd_a <= wb_dat_in[7:0];
      end
      if (wr_rsvd_b) begin
        rsvd_b <= wb_dat_in[7:0];
      end
      if (wr_rsvd_c) begin
        rsvd_c <= wb_dat_in[7:0];
      end
      if (wr_ctrl) begin
        pass_enable <= wb_dat_in[`PCR_CTRL_PASS];
      end
    end
  end

  // ***************************************
  // target and alias slots
  // ***************************************
  always @(posedge mclk_in) begin
    if (reset_in) begin
      for (i = 0; i < NSLOT; i = i + 1) begin
        tgt[i]        <= `PCR_TGT_RESET;
        alias_addr[i] <= `PCR_ALIAS_RESET;
      end
    end else begin
      if (wr_tgt0) begin
        tgt[0] <= wb_dat_in[7:1];
      end
      if (wr_tgt1) begin
        tgt[1] <= wb_dat_in[7:1];
      end
      if (wr_alias0) begin
        alias_addr[0] <= wb_dat_in[7:1];
      end
      if (wr_alias1) begin
        alias_addr[1] <= wb_dat_in[7:1];
      end
    end
  end

  // ***************************************
  // alias match and remap
  // ***************************************
  genvar g;
  generate
    for (g = 0; g < NSLOT; g = g + 1) begin : slot
      pcr_slot_match #(
        .AW (7)
      ) u_match (
        .alias_in   (alias_addr[g]),
        .target_in  (tgt[g]),
        .addr_in    (i2c_addr_in),
        .hit_out    (hits[g]),
        .target_out (tsel[g])
      );
    end
  endgenerate

  always @* begin
    next_target = 7'h00;
    for (k = 0; k < NSLOT; k = k + 1) begin
      next_target = next_target | tsel[k];
    end
  end

  // ***************************************
  // forward outputs
  // ***************************************
  always @(posedge mclk_in) begin
    if (reset_in) begin
      fwd_valid_out <= 1'b0;
      fwd_addr_out  <= 7'h00;
      fwd_hit_out   <= 1'b0;
    end else begin
      fwd_valid_out <= i2c_req_in && pass_enable && (hits != {NSLOT{1'b0}});
      fwd_hit_out   <= i2c_req_in && (hits != {NSLOT{1'b0}});
      fwd_addr_out  <= next_target;
    end
  end
endmodule

// *** sim/pcr_regs_sva.sv ***
// Purpose: port checks for pcr_regs
// Assumes: one clock, sync reset
// Notes:   bound below the module
`timescale 1ns/1ps
module pcr_regs_sva (
  input wire        mclk_in,
  input wire        reset_in,
  input wire        wb_cyc_in,
  input wire        wb_stb_in,
  input wire        wb_we_in,
  input wire [31:0] wb_adr_in,
  input wire [31:0] wb_dat_out,
  input wire        wb_ack_out,
  input wire        wb_err_out,
  input wire        i2c_req_in,
  input wire        fwd_valid_out,
  input wire        fwd_hit_out
);
  // ****
  // checks
  // ****
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  sequence s_req;
    wb_cyc_in && wb_stb_in && !wb_ack_out && !wb_err_out;
  endsequence
  sequence s_rd_tgt;
    s_req ##0 !wb_we_in && wb_adr_in == 32'he4;
  endsequence
  a_req_answer: assert property (s_req |=> wb_ack_out ^ wb_err_out)
    else $error("request not answered once");
  a_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack held");
  a_err_unmapped: assert property (s_req ##0 wb_adr_in == 32'h0 |=> wb_err_out)
    else $error("no err on unmapped");
  a_no_dual: assert property (!(wb_ack_out && wb_err_out))
    else $error("ack with err");
  a_upper_zero: assert property (wb_ack_out |-> wb_dat_out[31:8] == 24'h0)
    else $error("upper data set");
  a_tgt_bit0: assert property (s_rd_tgt |=> wb_dat_out[0] == 1'b0)
    else $error("target bit0 set");
  a_fwd_cause: assert property (fwd_valid_out |-> $past(i2c_req_in))
    else $error("forward without request");
  a_fwd_hit: assert property (fwd_valid_out |-> fwd_hit_out)
    else $error("forward without hit");
  a_reset_quiet: assert property ($fell(reset_in) |-> !wb_ack_out && !fwd_valid_out)
    else $error("output after reset");
endmodule
bind pcr_regs pcr_regs_sva chk_u (.mclk_in, .reset_in, .wb_cyc_in, .wb_stb_in, .wb_we_in,
  .wb_adr_in, .wb_dat_out, .wb_ack_out, .wb_err_out, .i2c_req_in, .fwd_valid_out,
  .fwd_hit_out);

// *** sim/pcr_partner.sv ***
// Purpose: back channel side of the remote deserializer
// Assumes: same clock as the device
// Notes:   stale lines are inverted
`timescale 1ns/1ps
module pcr_partner (
  input  wire       mclk_in,
  input  wire       link_up_in,
  input  wire [5:0] caps_in,
  input  wire [6:0] addr_in,
  output reg        link_out = 1'b0,
  output reg  [5:0] caps_out = 6'h0,
  output reg        addr_valid_out = 1'b0,
  output reg  [6:0] addr_out = 7'h0
);
  reg [1:0] age = 2'h0;
  // ****
  // link bring-up
  // ****
  always @(posedge mclk_in) begin
    link_out <= link_up_in;
    age <= !link_up_in ? 2'h0 : (age == 2'h3 ? age : age + 2'h1);
    caps_out <= (link_up_in && age != 2'h3) ? caps_in : ~caps_out;
    addr_valid_out <= link_up_in && age == 2'h0;
    addr_out <= (link_up_in && age == 2'h0) ? addr_in : ~addr_out;
  end
endmodule

// *** sim/test_pcr_regs.sv ***
// Purpose: self-checking bench for pcr_regs
// Assumes: partner model drives the back channel
// Notes:   one idle cycle between bus requests
`timescale 1ns/1ps
`define CHK(a, x) begin checks_done++; if ((a) !== (x)) begin err_count++; \
  $display("[ERR] %0t got %h want %h", $time, a, x); end end
module test_pcr_regs;
  reg         mclk_in = 1'b0;
  reg         reset_in = 1'b1;
  reg         cyc = 1'b0, stb = 1'b0, we = 1'b0, link = 1'b0, req = 1'b0, e;
  reg  [31:0] adr = 32'h0, wdat = 32'h0;
  reg  [5:0]  caps = 6'h0;
  reg  [3:0]  sel = 4'h0;
  reg  [6:0]  paddr = 7'h0, iaddr = 7'h0;
  reg  [7:0]  rd;
  wire [31:0] rdat;
  wire        ack, err, ldet, aval, fvalid, fhit;
  wire [5:0]  bcaps;
  wire [6:0]  baddr, faddr;
  int         err_count = 0, checks_done = 0, cyc_n = 0;
  pcr_partner part_u (.mclk_in(mclk_in), .link_up_in(link), .caps_in(caps), .addr_in(paddr),
    .link_out(ldet), .caps_out(bcaps), .addr_valid_out(aval), .addr_out(baddr));
  pcr_regs dut_u (.mclk_in(mclk_in), .reset_in(reset_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_dat_in(wdat), .wb_sel_in(sel), .wb_dat_out(rdat),
    .wb_ack_out(ack), .wb_err_out(err), .bc_link_detect_in(ldet), .bc_selftest_in(bcaps[5]),
    .bc_multiport_in(bcaps[4]), .bc_port_num_in(bcaps[3:0]), .bc_addr_valid_in(aval),
    .bc_des_addr_in(baddr), .i2c_req_in(req), .i2c_addr_in(iaddr), .fwd_valid_out(fvalid),
    .fwd_addr_out(faddr), .fwd_hit_out(fhit));
  initial forever #5 mclk_in = ~mclk_in;
  task complete_run;
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge mclk_in) begin
    cyc_n++;
    if (cyc_n == 2000) begin
      err_count++;
      complete_run;
    end
  end
  // ****
  // bus and link helpers
  // ****
  task automatic bus(input bit w, input [7:0] idx, input [7:0] wd);
    @(posedge mclk_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'h1;
    adr <= {22'h0, idx, 2'b00};
    wdat <= {24'h0, wd};
    do @(posedge mclk_in); while (ack !== 1'b1 && err !== 1'b1);
    rd = rdat[7:0];
    e = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    sel <= 4'h0;
  endtask
  task automatic rchk(input [7:0] idx, input [7:0] x);
    bus(1'b0, idx, 8'h00);
    `CHK(rd, x)
  endtask
  task automatic up(input [5:0] c, input [6:0] a);
    link <= 1'b0;
    repeat (3) @(posedge mclk_in);
    caps <= c;
    paddr <= a;
    link <= 1'b1;
    repeat (6) @(posedge mclk_in);
  endtask
  task automatic i2c(input [6:0] a, input v, input h, input [6:0] x);
    req <= 1'b1;
    iaddr <= a;
    @(posedge mclk_in);
    req <= 1'b0;
    @(posedge mclk_in);
    `CHK({fvalid, fhit, faddr}, {v, h, x})
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_reset_vals;
    bit [7:0] want [7] = '{8'h00, 8'h00, 8'h00, 8'h7a, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 7; i++) rchk(8'(8'h34 + i), want[i]);
    bus(1'b0, 8'h00, 8'h00);
    `CHK(e, 1'b1)
  endtask
  task automatic t_link_load;
    bus(1'b1, 8'h35, 8'h0f);
    up(6'h2a, 7'h55);
    rchk(8'h35, 8'h2a);
    rchk(8'h37, 8'haa);
    rchk(8'h43, 8'h03);
    up(6'h13, 7'h11);
    rchk(8'h35, 8'h13);
  endtask
  task automatic t_freeze;
    bus(1'b1, 8'h35, 8'h85);
    bus(1'b1, 8'h37, 8'h45);
    up(6'h3f, 7'h7f);
    rchk(8'h35, 8'h85);
    rchk(8'h37, 8'h45);
    rchk(8'h43, 8'h01);
  endtask
  task automatic t_remap;
    bus(1'b1, 8'h39, 8'h67);
    rchk(8'h39, 8'h66);
    bus(1'b1, 8'h3a, 8'h88);
    bus(1'b1, 8'h41, 8'h20);
    bus(1'b1, 8'h42, 8'h40);
    rchk(8'h41, 8'h20);
    bus(1'b1, 8'h40, 8'h01);
    i2c(7'h10, 1'b1, 1'b1, 7'h33);
    i2c(7'h20, 1'b1, 1'b1, 7'h44);
    i2c(7'h11, 1'b0, 1'b0, 7'h00);
    bus(1'b1, 8'h40, 8'h00);
    i2c(7'h10, 1'b0, 1'b1, 7'h33);
  endtask
  initial begin
    repeat (4) @(posedge mclk_in);
    reset_in <= 1'b0;
    t_reset_vals;
    t_link_load;
    t_freeze;
    t_remap;
    complete_run;
  end
endmodule
